//--- core/mscv_host.sv
// Host controller that drives the converter pins and buffers results.
`timescale 1ns/1ps
`default_nettype none
module mscv_host
  import mscv_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // User command side.
  input  wire logic       start,
  input  wire mscv_mode_t op_mode,
  output logic            busy,
  // User result side.
  output logic            res_valid,
  input  wire logic       res_ready,
  output mscv_word_t      res_word,
  // Converter pins.
  output mscv_ctl_t       ctl_pins,
  input  wire logic       done_n_pin,
  input  wire logic       ready_pin,
  input  wire logic [7:0] result_bus
);

  // Three-stage input synchronisers.
  logic [2:0] done_sync_ff, nxt_done_sync;
  logic [2:0] rdy_sync_ff,  nxt_rdy_sync;
  logic       done_lvl_ff,  nxt_done_lvl;
  logic       rdy_lvl_ff,   nxt_rdy_lvl;

  always_comb begin
    nxt_done_sync = {done_sync_ff[1:0], done_n_pin};
    nxt_rdy_sync  = {rdy_sync_ff[1:0], ready_pin};
    nxt_done_lvl  = done_lvl_ff;
    nxt_rdy_lvl   = rdy_lvl_ff;
    if (done_sync_ff[2] == done_sync_ff[1]) begin
      nxt_done_lvl = done_sync_ff[2];
    end
    if (rdy_sync_ff[2] == rdy_sync_ff[1]) begin
      nxt_rdy_lvl = rdy_sync_ff[2];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_sync_ff <= 3'h7;
      rdy_sync_ff  <= 3'h7;
      done_lvl_ff  <= 1'b1;
      rdy_lvl_ff   <= 1'b1;
    end else begin
      done_sync_ff <= nxt_done_sync;
      rdy_sync_ff  <= nxt_rdy_sync;
      done_lvl_ff  <= nxt_done_lvl;
      rdy_lvl_ff   <= nxt_rdy_lvl;
    end
  end

  // Sequencer.
  mscv_state_t      st_ff,    nxt_st;
  mscv_mode_t       mode_ff,  nxt_mode;
  mscv_ctl_t        ctl_ff,   nxt_ctl;
  logic [CNT_W-1:0] cnt_ff,   nxt_cnt;
  logic [7:0]       data_ff,  nxt_data;
  logic             tout_ff,  nxt_tout;
  logic [1:0]       pcnt_ff,  nxt_pcnt;
  logic             push;
  logic             buf_in_ready;

  function automatic logic [CNT_W-1:0] cval(input int unsigned c);
    return c[CNT_W-1:0];
  endfunction

  always_comb begin
    nxt_st   = st_ff;
    nxt_mode = mode_ff;
    nxt_ctl  = ctl_ff;
    nxt_cnt  = cnt_ff + 9'h001;
    nxt_data = data_ff;
    nxt_tout = tout_ff;
    nxt_pcnt = pcnt_ff;
    push     = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        nxt_cnt = CNT_RST;
        if (start) begin
          nxt_mode      = op_mode;
          nxt_tout      = 1'b0;
          nxt_ctl.mode  = op_mode[1];
          nxt_ctl.cs_n  = 1'b0;
          if (op_mode[1]) begin
            nxt_ctl.wr_n = 1'b0;
            nxt_st       = ST_WR_LO;
          end else begin
            nxt_ctl.rd_n = 1'b0;
            nxt_st       = ST_RD_LO;
          end
        end else begin
          nxt_ctl.mode = op_mode[1];
        end
      end
      ST_WR_LO: begin
        if (cnt_ff >= cval(C_WR_PULSE)) begin
          nxt_ctl.wr_n = 1'b1;
          nxt_cnt      = CNT_RST;
          nxt_st       = ST_WR_HI;
        end
      end
      // Conversion-done stays low from the last conversion, so it is trusted only after
      // the synchroniser has had time to see it rise again.
      ST_WR_HI: begin
        if (mode_ff == MSCV_WR_FAST && cnt_ff >= cval(C_WR_EARLY_RD)) begin
          nxt_ctl.rd_n = 1'b0;
          nxt_cnt      = CNT_RST;
          nxt_st       = ST_ACCESS;
        end else if (mode_ff == MSCV_WR_WAIT && !done_lvl_ff && cnt_ff > cval(C_ACCESS)) begin
          nxt_ctl.rd_n = 1'b0;
          nxt_cnt      = CNT_RST;
          nxt_st       = ST_ACCESS;
        end else if (cnt_ff >= cval(C_REDUCED_DATA)) begin
          nxt_ctl.rd_n = 1'b0;
          nxt_tout     = (mode_ff == MSCV_WR_WAIT);
          nxt_cnt      = CNT_RST;
          nxt_st       = ST_ACCESS;
        end
      end
      ST_RD_LO: begin
        if (mode_ff == MSCV_PIPE) begin
          if (cnt_ff >= cval(C_PIPE_RD)) begin
            nxt_data     = result_bus;
            nxt_ctl.rd_n = 1'b1;
            nxt_ctl.cs_n = 1'b1;
            nxt_cnt      = CNT_RST;
            if (pcnt_ff < PIPE_DISCARD[1:0]) begin
              nxt_pcnt = pcnt_ff + 2'h1;
              nxt_st   = ST_GAP;
            end else begin
              nxt_st = ST_PUSH;
            end
          end
        end else if ((!done_lvl_ff || rdy_lvl_ff) && cnt_ff > cval(C_ACCESS)) begin
          nxt_cnt = CNT_RST;
          nxt_st  = ST_ACCESS;
        end else if (cnt_ff >= cval(C_RDONLY_MAX)) begin
          nxt_tout = 1'b1;
          nxt_cnt  = CNT_RST;
          nxt_st   = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (cnt_ff >= cval(C_ACCESS)) begin
          nxt_data     = result_bus;
          nxt_ctl.rd_n = 1'b1;
          nxt_ctl.cs_n = 1'b1;
          nxt_st       = ST_PUSH;
        end
      end
      ST_PUSH: begin
        nxt_cnt = CNT_RST;
        if (buf_in_ready) begin
          push   = 1'b1;
          nxt_st = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_ff >= cval((C_CS_GAP > C_READ_GAP) ? C_CS_GAP : C_READ_GAP)) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    if (nxt_mode != MSCV_PIPE && st_ff == ST_IDLE && start) begin
      nxt_pcnt = PCNT_RST;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff   <= ST_IDLE;
      mode_ff <= MSCV_RDONLY;
      ctl_ff  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, mode: 1'b0};
      cnt_ff  <= CNT_RST;
      data_ff <= DATA_RST;
      tout_ff <= 1'b0;
      pcnt_ff <= PCNT_RST;
    end else begin
      st_ff   <= nxt_st;
      mode_ff <= nxt_mode;
      ctl_ff  <= nxt_ctl;
      cnt_ff  <= nxt_cnt;
      data_ff <= nxt_data;
      tout_ff <= nxt_tout;
      pcnt_ff <= nxt_pcnt;
    end
  end

  assign ctl_pins = ctl_ff;
  // Holding the next conversion while the buffer is full keeps every word.
  assign busy     = (st_ff != ST_IDLE);

  // Two-entry result buffer.
  mscv_word_t buf_ff [2];
  mscv_word_t nxt_buf [2];
  logic [1:0] fill_ff, nxt_fill;

  assign buf_in_ready = (fill_ff != 2'h2);
  assign res_valid    = (fill_ff != 2'h0);
  assign res_word     = buf_ff[0];

  always_comb begin
    logic pop;
    pop      = res_valid && res_ready;
    nxt_buf  = buf_ff;
    nxt_fill = fill_ff;
    if (pop) begin
      nxt_buf[0] = buf_ff[1];
    end
    if (push) begin
      nxt_buf[(pop ? fill_ff - 2'h1 : fill_ff) == 2'h0 ? 0 : 1] = '{timeout: tout_ff,
                                                                     result: data_ff};
    end
    nxt_fill = fill_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      fill_ff   <= 2'h0;
    end else begin
      buf_ff   <= nxt_buf;
      fill_ff  <= nxt_fill;
    end
  end

endmodule
`default_nettype wire

//--- core/mscv_pkg.sv
// Package with constants and types for the converter host controller.
package mscv_pkg;

  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Host-side timing figures in nanoseconds.
  localparam int unsigned T_RDONLY_TYP_NS   = 655;
  localparam int unsigned T_CS_GAP_NS       = 50;
  localparam int unsigned T_PIPE_RD_MIN_NS  = 200;
  localparam int unsigned T_PIPE_RD_MAX_NS  = 400;
  localparam int unsigned T_WR_DONE_MAX_NS  = 690;
  localparam int unsigned T_WR_EARLY_RD_NS  = 350;
  localparam int unsigned T_FAST_CONV_NS    = 560;
  localparam int unsigned T_READ_GAP_NS     = 100;
  localparam int unsigned T_REDUCED_DATA_NS = 705;
  localparam int unsigned T_WR_PULSE_NS     = 100;
  localparam int unsigned T_ACCESS_NS       = 100;

  // Least times round up, longest times round down except C_WR_DONE_MAX, none below one cycle.
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int unsigned cyc_dn(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned C_RDONLY_MAX   = cyc_dn(T_RDONLY_TYP_NS * 2);
  localparam int unsigned C_CS_GAP       = cyc_up(T_CS_GAP_NS);
  localparam int unsigned C_PIPE_RD      = cyc_up((T_PIPE_RD_MIN_NS + T_PIPE_RD_MAX_NS) / 2);
  localparam int unsigned C_PIPE_RD_MIN  = cyc_up(T_PIPE_RD_MIN_NS);
  localparam int unsigned C_PIPE_RD_MAX  = cyc_dn(T_PIPE_RD_MAX_NS);
  localparam int unsigned C_WR_DONE_MAX  = cyc_up(T_WR_DONE_MAX_NS);
  localparam int unsigned C_WR_EARLY_RD  = cyc_up(T_WR_EARLY_RD_NS);
  localparam int unsigned C_FAST_CONV    = cyc_up(T_FAST_CONV_NS);
  localparam int unsigned C_READ_GAP     = cyc_up(T_READ_GAP_NS);
  localparam int unsigned C_REDUCED_DATA = cyc_up(T_REDUCED_DATA_NS);
  localparam int unsigned C_WR_PULSE     = cyc_up(T_WR_PULSE_NS);
  localparam int unsigned C_ACCESS       = cyc_up(T_ACCESS_NS);

  localparam int unsigned CNT_W = 9;
  localparam int unsigned PIPE_DISCARD = 2;

  localparam logic [CNT_W-1:0] CNT_RST  = 9'h000;
  localparam logic [7:0]       DATA_RST = 8'h00;
  localparam logic [1:0]       PCNT_RST = 2'h0;

  typedef enum logic [1:0] {
    MSCV_RDONLY  = 2'b00,
    MSCV_PIPE    = 2'b01,
    MSCV_WR_WAIT = 2'b10,
    MSCV_WR_FAST = 2'b11
  } mscv_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_WR_LO  = 4'b0001,
    ST_WR_HI  = 4'b0010,
    ST_RD_LO  = 4'b0011,
    ST_ACCESS = 4'b0100,
    ST_PUSH   = 4'b0101,
    ST_GAP    = 4'b0110,
    ST_FAIL   = 4'b0111
  } mscv_state_t;

  // Pins that the host drives toward the converter.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic mode;
  } mscv_ctl_t;

  // Word handed to the user side.
  typedef struct packed {
    logic       timeout;
    logic [7:0] result;
  } mscv_word_t;

endpackage

//--- verif/mscv_host_props.sv
// Checker that watches the ports of the converter host controller.
`timescale 1ns/1ps
`default_nettype none
module mscv_host_props
  import mscv_pkg::*;
(
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // User side.
  input wire logic       start,
  input wire mscv_mode_t op_mode,
  input wire logic       busy,
  input wire logic       res_valid,
  input wire logic       res_ready,
  input wire mscv_word_t res_word,
  // Converter pins.
  input wire mscv_ctl_t  ctl_pins,
  input wire logic       done_n_pin,
  input wire logic       ready_pin,
  input wire logic [7:0] result_bus
);
  logic [7:0] lc_ff;
  logic [7:0] wc_ff;
  mscv_mode_t mo_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // The mode is latched here because the pins alone cannot tell pipelined reads apart.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lc_ff <= 8'h00;
      wc_ff <= 8'h00;
      mo_ff <= MSCV_RDONLY;
    end else begin
      lc_ff <= ctl_pins.rd_n ? 8'h00 : lc_ff + 8'h01;
      wc_ff <= !ctl_pins.wr_n ? 8'h00 : wc_ff + {7'h00, wc_ff != 8'hff};
      if (start && !busy) begin
        mo_ff <= op_mode;
      end
    end
  end
  property p_rd_cs; !ctl_pins.rd_n |-> !ctl_pins.cs_n; endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read without select");
  property p_wr_mode; !ctl_pins.wr_n |-> ctl_pins.mode; endproperty
  a_wr_mode: assert property (p_wr_mode) else $error("write with mode low");
  property p_mode_pin; !ctl_pins.cs_n |-> ctl_pins.mode == mo_ff[1]; endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("mode pin wrong");
  property p_start; start && !busy |=> ##[0:1] !ctl_pins.cs_n; endproperty
  a_start: assert property (p_start) else $error("select late");
  property p_gap; $rose(ctl_pins.cs_n) |-> ctl_pins.cs_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("gap short");
  property p_pipe; $rose(ctl_pins.rd_n) && mo_ff == MSCV_PIPE |-> lc_ff inside {[8'h19:8'h32]};
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipe read width");
  property p_early;
    $fell(ctl_pins.rd_n) && mo_ff == MSCV_WR_FAST |-> wc_ff inside {[8'h2b:8'h2e]};
  endproperty
  a_early: assert property (p_early) else $error("early read time");
  property p_wait;
    mo_ff == MSCV_RDONLY && !ctl_pins.rd_n && done_n_pin && !ready_pin && lc_ff < 8'h96
      |=> !ctl_pins.rd_n;
  endproperty
  a_wait: assert property (p_wait) else $error("read released early");
  property p_wr_w; $fell(ctl_pins.wr_n) |-> !ctl_pins.wr_n [*8] ##[1:8] ctl_pins.wr_n; endproperty
  a_wr_w: assert property (p_wr_w) else $error("write width");
  property p_hold; res_valid && !res_ready |=> res_valid && $stable(res_word); endproperty
  a_hold: assert property (p_hold) else $error("word not held");
endmodule
`default_nettype wire

//--- verif/mscv_dev_model.sv
// Behavioural model of the converter seen from its pins.
`timescale 1ns/1ps
`default_nettype none
module mscv_dev_model
  import mscv_pkg::*;
(
  // Clock and pins.
  input  wire logic       clk,
  input  wire mscv_ctl_t  ctl,
  output logic            done_n,
  output logic            rdy,
  output logic [7:0]      bus,
  // Scenario controls.
  input  wire logic [7:0] val,
  input  wire logic [7:0] dur
);
  logic       cv = 1'b0;
  logic [7:0] n = 8'h00;
  logic [7:0] res = 8'h3c;
  logic [7:0] old = 8'hc3;
  mscv_ctl_t  p = 4'he;
  initial begin
    done_n = 1'b1;
    rdy = 1'b1;
  end
  // Two flash steps on ideal ladders. The flash windows overlap, so an estimate one step
  // off still leaves the input inside the range of the eight comparators.
  function automatic logic [7:0] two_step(input logic [7:0] v);
    int c;
    int e;
    int t;
    int f;
    int u;
    c = 0;
    for (int k = 0; k < 6; k++) c += (int'(v) >= 60 + 32 * k) ? 1 : 0;
    e = (c + 1) / 2;
    t = 0;
    for (int k = 1; k <= 8; k++) t += (int'(v) >= 64 * e - 8 + 8 * k) ? 1 : 0;
    if (t < 4) begin
      e = e - 1;
      f = t + 7;
    end else begin
      f = t - 1;
    end
    u = 8 * e + f;
    t = 0;
    for (int k = 1; k < 8; k++) t += (int'(v) - 8 * u >= k) ? 1 : 0;
    return {u[4:0], 3'(t)};
  endfunction
  // A released bus shows the inverse so that a stale sample cannot match.
  assign bus = (ctl.cs_n || ctl.rd_n) ? ~res : (cv ? old : res);
  always @(posedge clk) begin
    p <= ctl;
    if (cv && (n == 8'h00 || (ctl.mode && !ctl.rd_n && p.rd_n))) begin
      cv <= 1'b0;
      res <= two_step(val);
      done_n <= 1'b0;
      rdy <= 1'b1;
    end else if (cv) begin
      n <= n - 8'h01;
    end
    if ((ctl.mode ? (ctl.wr_n && !p.wr_n) : (!ctl.rd_n && p.rd_n)) && !ctl.cs_n) begin
      cv <= 1'b1;
      n <= dur;
      old <= res;
      done_n <= 1'b1;
    end
    if (!ctl.cs_n && p.cs_n) begin
      rdy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the converter host controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mscv_pkg::*;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       start = 1'b0;
  logic       res_ready = 1'b0;
  logic       busy, res_valid, done_n, rdy;
  logic [7:0] bus;
  logic [7:0] val = 8'h00;
  logic [7:0] dur = 8'h28;
  logic [7:0] pv = 8'h00;
  mscv_mode_t op_mode = MSCV_RDONLY;
  mscv_word_t res_word;
  mscv_word_t q[$];
  mscv_ctl_t  ctl;
  int         seed = 45;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         i;
  bit         hold = 1'b0;
  always #4 sys_clk = ~sys_clk;
  mscv_host DUT (.sys_clk, .sys_rst, .start, .op_mode, .busy, .res_valid, .res_ready,
    .res_word, .ctl_pins(ctl), .done_n_pin(done_n), .ready_pin(rdy), .result_bus(bus));
  mscv_dev_model u_dev (.clk(sys_clk), .ctl, .done_n, .rdy, .bus, .val, .dur);
  task automatic cmp_word(input mscv_word_t e, input mscv_word_t g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_flag(input logic e, input logic g);
    cmp_word({8'h00, e}, {8'h00, g});
  endtask
  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic idle_wait;
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge sys_clk);
    if (busy !== 1'b0) begin
      n_fail++;
      end_of_test();
    end
  endtask
  // Pipelined reads show the word of the conversion before, hence pv.
  task automatic conv(input mscv_mode_t m, input logic [7:0] d, input bit keep, input logic to);
    idle_wait();
    val = 8'($random(seed));
    dur = d;
    op_mode = m;
    start = 1'b1;
    if (keep) q.push_back({to, (m == MSCV_PIPE) ? pv : val});
    pv = val;
    @(negedge sys_clk);
    start = 1'b0;
  endtask
  always @(negedge sys_clk) res_ready <= hold ? 1'b0 : 1'($random(seed));
  always @(posedge sys_clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      if (q.size() == 0) cmp_word(9'h000, res_word);
      else cmp_word(q.pop_front(), res_word);
    end
  end
  initial begin
    #240000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    conv(MSCV_RDONLY, 8'h28, 1'b1, 1'b0);
    conv(MSCV_RDONLY, 8'h52, 1'b1, 1'b0);
    conv(MSCV_WR_WAIT, 8'h28, 1'b1, 1'b0);
    conv(MSCV_WR_WAIT, 8'h46, 1'b1, 1'b0);
    conv(MSCV_WR_WAIT, 8'h78, 1'b1, 1'b1);
    conv(MSCV_WR_FAST, 8'h1e, 1'b1, 1'b0);
    conv(MSCV_WR_FAST, 8'h46, 1'b1, 1'b0);
    for (i = 0; i < 4; i++) conv(MSCV_PIPE, 8'h2d, i >= 2, 1'b0);
    idle_wait();
    repeat (40) @(negedge sys_clk);
    hold = 1'b1;
    repeat (3) conv(MSCV_RDONLY, 8'h28, 1'b1, 1'b0);
    repeat (200) @(negedge sys_clk);
    cmp_flag(1'b1, busy);
    cmp_flag(1'b1, res_valid);
    hold = 1'b0;
    idle_wait();
    repeat (40) @(negedge sys_clk);
    cmp_flag(1'b0, res_valid);
    cmp_flag(1'b1, q.size() == 0);
    end_of_test();
  end
endmodule
bind mscv_host mscv_host_props u_props (.sys_clk, .sys_rst, .start, .op_mode, .busy,
  .res_valid, .res_ready, .res_word, .ctl_pins, .done_n_pin, .ready_pin, .result_bus);
`default_nettype wire
